// [core/tdr_regs.svh]
// Register offsets, reset values, codes and link framing counts for the debug port
`ifndef TDR_REGS_SVH
`define TDR_REGS_SVH

`define TDR_ADDR_PART_ID     8'h00
`define TDR_ADDR_REVISION    8'h01
`define TDR_ADDR_PROG_CTL    8'h02
`define TDR_ADDR_PROG_DATA   8'hb4

`define TDR_RST_SELECT       8'h00
`define TDR_RST_PROG_CTL     8'h00
`define TDR_RST_PROG_DATA    8'h00

`define TDR_UNLOCK_FIRST     8'h02
`define TDR_UNLOCK_SECOND    8'h01

`define TDR_CMD_BLOCK_READ   8'h06
`define TDR_CMD_BLOCK_WRITE  8'h07
`define TDR_CMD_PAGE_ERASE   8'h08
`define TDR_CMD_DEVICE_ERASE 8'h03

`define TDR_INSTR_LAST       3'h1
`define TDR_BYTE_LAST        3'h7

`define TDR_STAT_ENABLED     0
`define TDR_STAT_RDBK_VALID  1
`define TDR_STAT_BUSY        2
`define TDR_STAT_CMD_ERR     3

`endif

// [core/tdr_pkg.sv]
// Types shared by the debug port logic
package tdr_pkg;

	typedef enum logic [4:0] {
		TDR_LNK_IDLE  = 5'h01,
		TDR_LNK_INSTR = 5'h02,
		TDR_LNK_WDATA = 5'h04,
		TDR_LNK_RDATA = 5'h08,
		TDR_LNK_PUSH  = 5'h10
	} tdr_link_st_t;

	typedef enum logic [2:0] {
		TDR_CTL_LOCKED  = 3'h1,
		TDR_CTL_ARMED   = 3'h2,
		TDR_CTL_ENABLED = 3'h4
	} tdr_ctl_st_t;

endpackage : tdr_pkg

// [core/tdr_fifo.sv]
// Small shift-style FIFO; head word always sits in a flip-flop
`timescale 1ns/1ns
module tdr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// Drain side
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [CW-1:0]    count_r;
	logic             push;
	logic             pop;

	assign in_ready_o = (count_r != CW'(DEPTH));
	assign push       = in_valid_i & in_ready_o;
	assign pop        = out_valid_o & out_ready_i;
	assign out_data_o = mem_r[0];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_r     <= '0;
			out_valid_o <= 1'b0;
		end else begin
			count_r     <= CW'(count_r + CW'(push) - CW'(pop));
			out_valid_o <= (CW'(count_r + CW'(push) - CW'(pop)) != '0);
		end
	end

	// Storage carries no reset; only count decides what is valid
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (pop) begin
				if (push && (CW'(i) == CW'(count_r - 1'b1)))
					mem_r[i] <= in_data_i;
				else if (i < DEPTH - 1)
					mem_r[i] <= mem_r[(i < DEPTH - 1) ? i + 1 : i];
			end else if (push && (CW'(i) == count_r)) begin
				mem_r[i] <= in_data_i;
			end
		end
	end

endmodule : tdr_fifo

// [core/tdr_link_regs.sv]
// Two-wire debug port: link receiver, register file and programming unlock
`timescale 1ns/1ns
`include "tdr_regs.svh"

// Contract
// R1 - Address zero reads fixed part identification
// R2 - Address one reads silicon revision code
// R3 - Control writes 0x02 then 0x01 unlock
// R4 - Programming mode holds until system reset
// R5 - Data register carries flash commands and data
// R6 - Command codes: read, write, page, device erase
// R7 - Halt stalls core so pins shared
// R8 - Address register selects data register target
// R9 - Link: host clock plus bidirectional data
// R10 - Writes to identification registers ignored
module tdr_link_regs #(
	parameter logic [7:0] PART_ID  = 8'ha5, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h5c, // Arbitrary value
	parameter int         FIFO_DEPTH = 4
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Link pins
	input  wire logic       link_clock_line_i,
	input  wire logic       link_data_line_i,
	output logic            link_data_line_o,
	output logic            link_data_line_oe_o,
	// Core control
	input  wire logic       halt_req_i,
	output logic            core_stall_o,
	output logic            prog_enable_o,
	// Flash side byte stream
	output logic            fl_valid_o,
	output logic [7:0]      fl_byte_o,
	output logic            fl_is_cmd_o,
	input  wire logic       fl_ready_i,
	input  wire logic       fl_rvalid_i,
	input  wire logic [7:0] fl_rdata_i,
	input  wire logic       fl_done_i
);

	function automatic logic is_cmd_code(input logic [7:0] b);
		return (b == `TDR_CMD_BLOCK_READ) || (b == `TDR_CMD_BLOCK_WRITE) ||
		       (b == `TDR_CMD_PAGE_ERASE) || (b == `TDR_CMD_DEVICE_ERASE);
	endfunction : is_cmd_code
	logic                  ck_s1_r, ck_s2_r, ck_s3_r;
	logic                  dat_s1_r, dat_s2_r;
	logic                  rise;
	tdr_pkg::tdr_link_st_t lnk_st_r;
	tdr_pkg::tdr_ctl_st_t  ctl_st_r;
	logic [2:0]            cnt_r;
	logic                  instr_wr_r;
	logic                  instr_adr_r;
	logic [7:0]            shift_r;
	logic [7:0]            select_r;
	logic [7:0]            ctl_r;
	logic [7:0]            rdbk_r;
	logic                  rdbk_v_r;
	logic                  expect_cmd_r;
	logic                  cmd_err_r;
	logic                  push_cmd_r;
	logic                  wr_fire;
	logic                  rd_fire;
	logic [7:0]            wr_byte;
	logic [7:0]            rd_val;
	logic [7:0]            status;
	logic                  fifo_in_ready;
	logic                  push_ok;
	logic                  data_wr;
	logic [8:0]            fifo_out;
	// R9 link pin sampling
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ck_s1_r  <= 1'b0;
			ck_s2_r  <= 1'b0;
			ck_s3_r  <= 1'b0;
			dat_s1_r <= 1'b0;
			dat_s2_r <= 1'b0;
		end else begin
			ck_s1_r  <= link_clock_line_i;
			ck_s2_r  <= ck_s1_r;
			ck_s3_r  <= ck_s2_r;
			dat_s1_r <= link_data_line_i;
			dat_s2_r <= dat_s1_r;
		end
	end
	assign rise    = ck_s2_r & ~ck_s3_r;
	assign wr_byte = {dat_s2_r, shift_r[7:1]};
	assign wr_fire = (lnk_st_r == tdr_pkg::TDR_LNK_WDATA) && rise && (cnt_r == `TDR_BYTE_LAST);
	assign rd_fire = (lnk_st_r == tdr_pkg::TDR_LNK_INSTR) && rise &&
	                 (cnt_r == `TDR_INSTR_LAST) && !instr_wr_r;
	assign data_wr = wr_fire && !instr_adr_r;
	assign push_ok = (lnk_st_r == tdr_pkg::TDR_LNK_PUSH) && fifo_in_ready;
	always_comb begin
		status = 8'h00;
		status[`TDR_STAT_ENABLED]    = prog_enable_o;
		status[`TDR_STAT_RDBK_VALID] = rdbk_v_r;
		status[`TDR_STAT_BUSY]       = ~fifo_in_ready;
		status[`TDR_STAT_CMD_ERR]    = cmd_err_r;
	end
	// R8 read target chosen by select; reads with the address flag set return status
	always_comb begin
		if (dat_s2_r)
			rd_val = status;
		else begin
			// R10 fixed values at addresses zero and one, writes cannot alter
			unique case (select_r)
				// R1 identification readback
				`TDR_ADDR_PART_ID:   rd_val = PART_ID;
				// R2 revision readback
				`TDR_ADDR_REVISION:  rd_val = REVISION;
				`TDR_ADDR_PROG_CTL:  rd_val = ctl_r;
				`TDR_ADDR_PROG_DATA: rd_val = rdbk_r;
				default:             rd_val = 8'h00;
			endcase
		end
	end
	AST_ID_READ: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		(rd_fire && !dat_s2_r && select_r == `TDR_ADDR_PART_ID) |=>
		(shift_r == PART_ID) && link_data_line_oe_o && (link_data_line_o == PART_ID[0]))
		else $error("identification read wrong");
	AST_REV_READ: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		(rd_fire && !dat_s2_r && select_r == `TDR_ADDR_REVISION) |=> (shift_r == REVISION))
		else $error("revision read wrong");
	// Framing: start bit high, write flag, address flag, 8 bits LSB first
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lnk_st_r            <= tdr_pkg::TDR_LNK_IDLE;
			cnt_r               <= 3'h0;
			instr_wr_r          <= 1'b0;
			instr_adr_r         <= 1'b0;
			shift_r             <= 8'h00;
			link_data_line_o    <= 1'b0;
			link_data_line_oe_o <= 1'b0;
		end else begin
			unique case (lnk_st_r)
				tdr_pkg::TDR_LNK_IDLE: if (rise && dat_s2_r) begin
					lnk_st_r <= tdr_pkg::TDR_LNK_INSTR;
					cnt_r    <= 3'h0;
				end
				tdr_pkg::TDR_LNK_INSTR: if (rise) begin
					cnt_r <= 3'(cnt_r + 1'b1);
					if (cnt_r == 3'h0)
						instr_wr_r <= dat_s2_r;
					else begin
						instr_adr_r <= dat_s2_r;
						cnt_r       <= 3'h0;
						if (instr_wr_r)
							lnk_st_r <= tdr_pkg::TDR_LNK_WDATA;
						else begin
							// R9 device drives data line on reads
							lnk_st_r            <= tdr_pkg::TDR_LNK_RDATA;
							shift_r             <= rd_val;
							link_data_line_o    <= rd_val[0];
							link_data_line_oe_o <= 1'b1;
						end
					end
				end
				tdr_pkg::TDR_LNK_WDATA: if (rise) begin
					cnt_r   <= 3'(cnt_r + 1'b1);
					shift_r <= wr_byte;
					// R5 data register fed to flash path
					if (cnt_r == `TDR_BYTE_LAST)
						lnk_st_r <= (!instr_adr_r && prog_enable_o &&
						             select_r == `TDR_ADDR_PROG_DATA &&
						             !(expect_cmd_r && !is_cmd_code(wr_byte))) ?
						            tdr_pkg::TDR_LNK_PUSH : tdr_pkg::TDR_LNK_IDLE;
				end
				tdr_pkg::TDR_LNK_RDATA: if (rise) begin
					cnt_r            <= 3'(cnt_r + 1'b1);
					shift_r          <= {1'b0, shift_r[7:1]};
					link_data_line_o <= shift_r[1];
					if (cnt_r == `TDR_BYTE_LAST) begin
						lnk_st_r            <= tdr_pkg::TDR_LNK_IDLE;
						link_data_line_oe_o <= 1'b0;
					end
				end
				// Full FIFO stalls here; frames meanwhile are not seen
				tdr_pkg::TDR_LNK_PUSH: if (fifo_in_ready)
					lnk_st_r <= tdr_pkg::TDR_LNK_IDLE;
			endcase
		end
	end
	AST_PUSH_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		(lnk_st_r == tdr_pkg::TDR_LNK_PUSH) |-> prog_enable_o)
		else $error("data pushed while locked");
	AST_DRIVE_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		(lnk_st_r == tdr_pkg::TDR_LNK_IDLE) |-> !link_data_line_oe_o)
		else $error("data line driven outside read");
	// R8 select register write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			select_r <= `TDR_RST_SELECT;
		else if (wr_fire && instr_adr_r)
			select_r <= wr_byte;
	end
	AST_SELECT: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		(wr_fire && instr_adr_r) |=> (select_r == $past(wr_byte)))
		else $error("select register not loaded");
	// R3 ordered unlock sequence
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_st_r      <= tdr_pkg::TDR_CTL_LOCKED;
			ctl_r         <= `TDR_RST_PROG_CTL;
			prog_enable_o <= 1'b0;
		end else if (data_wr && select_r == `TDR_ADDR_PROG_CTL) begin
			ctl_r <= wr_byte;
			unique case (ctl_st_r)
				tdr_pkg::TDR_CTL_LOCKED:
					if (wr_byte == `TDR_UNLOCK_FIRST)
						ctl_st_r <= tdr_pkg::TDR_CTL_ARMED;
				tdr_pkg::TDR_CTL_ARMED:
					if (wr_byte == `TDR_UNLOCK_SECOND) begin
						ctl_st_r      <= tdr_pkg::TDR_CTL_ENABLED;
						prog_enable_o <= 1'b1;
					end else if (wr_byte != `TDR_UNLOCK_FIRST)
						ctl_st_r <= tdr_pkg::TDR_CTL_LOCKED;
				// R4 no way back short of reset
				tdr_pkg::TDR_CTL_ENABLED: ctl_st_r <= tdr_pkg::TDR_CTL_ENABLED;
			endcase
		end
	end
	AST_UNLOCK: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		$rose(prog_enable_o) |-> ($past(ctl_st_r) == tdr_pkg::TDR_CTL_ARMED) &&
		($past(wr_byte) == `TDR_UNLOCK_SECOND))
		else $error("programming enabled without unlock order");
	AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		prog_enable_o |=> prog_enable_o)
		else $error("programming mode left without reset");
	AST_RO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		(data_wr && select_r <= `TDR_ADDR_REVISION) |=>
		(ctl_st_r == $past(ctl_st_r)) && (lnk_st_r == tdr_pkg::TDR_LNK_IDLE))
		else $error("write to read-only register had effect");
	// R7 stall core while halted or programming
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			core_stall_o <= 1'b0;
		else
			core_stall_o <= halt_req_i | prog_enable_o;
	end
	AST_STALL: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		(prog_enable_o || halt_req_i) |=> core_stall_o)
		else $error("core not stalled");
	// R6 command byte classification
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			expect_cmd_r <= 1'b1;
			cmd_err_r    <= 1'b0;
			push_cmd_r   <= 1'b0;
		end else begin
			if (fl_done_i)
				expect_cmd_r <= 1'b1;
			else if (push_ok && push_cmd_r)
				expect_cmd_r <= 1'b0;
			if (data_wr && select_r == `TDR_ADDR_PROG_DATA && prog_enable_o)
				push_cmd_r <= expect_cmd_r;
			// Error set wins over the clear by a status read
			if (data_wr && select_r == `TDR_ADDR_PROG_DATA && prog_enable_o &&
			    expect_cmd_r && !is_cmd_code(wr_byte))
				cmd_err_r <= 1'b1;
			else if (rd_fire && dat_s2_r)
				cmd_err_r <= 1'b0;
		end
	end
	AST_CMD_CODE: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		(push_ok && push_cmd_r) |-> is_cmd_code(shift_r))
		else $error("invalid command passed to flash");
	// R5 flash read data returned to host
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdbk_r   <= `TDR_RST_PROG_DATA;
			rdbk_v_r <= 1'b0;
		end else if (fl_rvalid_i) begin
			rdbk_r   <= fl_rdata_i;
			rdbk_v_r <= 1'b1;
		end else if (rd_fire && !dat_s2_r && select_r == `TDR_ADDR_PROG_DATA)
			rdbk_v_r <= 1'b0;
	end

	tdr_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (lnk_st_r == tdr_pkg::TDR_LNK_PUSH),
		.in_data_i   ({push_cmd_r, shift_r}),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fl_valid_o),
		.out_data_o  (fifo_out),
		.out_ready_i (fl_ready_i)
	);

	assign fl_byte_o   = fifo_out[7:0];
	assign fl_is_cmd_o = fifo_out[8];

endmodule : tdr_link_regs

// [dv/tdr_link_host.sv]
// Behavioural debug host: drives the link clock and data line
`timescale 1ns/1ns
module tdr_link_host (
	// Clock
	input  wire logic clk_i,
	// Device side of the data pin
	input  wire logic dev_d_i,
	input  wire logic dev_oe_i,
	// Link pins
	output logic      ck_o,
	output logic      line_o
);
	logic oe_r;
	logic d_r;
	logic rel_r;

	initial begin
		ck_o = 1'b0;
		oe_r = 1'b1;
		d_r  = 1'b0;
		rel_r = 1'b0;
	end

	// No pull on the line, so a released pin toggles
	always @(posedge clk_i) begin
		rel_r <= ~rel_r;
	end

	assign line_o = dev_oe_i ? dev_d_i : (oe_r ? d_r : rel_r);

	task automatic tick(input logic b, input logic drv, output logic s);
		@(posedge clk_i);
		oe_r <= drv;
		d_r  <= b;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		s = line_o;
		@(posedge clk_i);
		ck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		ck_o <= 1'b0;
	endtask : tick

	// start, direction, select flag, byte LSB first
	task automatic frame(input logic w, input logic a, input logic [7:0] d,
		output logic [7:0] q);
		logic s;
		tick(1'b1, 1'b1, s);
		tick(w, 1'b1, s);
		tick(a, 1'b1, s);
		for (int i = 0; i < 8; i++) begin
			tick(w & d[i], w, s);
			q[i] = s;
		end
		// Line held low between frames so no false start
		oe_r <= 1'b1;
		d_r  <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : frame
endmodule : tdr_link_host

// [dv/two_wire_debug_flash_regs_test.sv]
// Self-checking bench for the debug port register file
`timescale 1ns/1ns
module two_wire_debug_flash_regs_test;
	// Identification values, arbitrary
	localparam logic [7:0] PID = 8'h3c;
	localparam logic [7:0] REV = 8'h4b;
	logic       clk = 1'b0;
	logic       rst;
	logic       lck;
	logic       line;
	logic       dq;
	logic       doe;
	logic       halt;
	logic       stall;
	logic       prog;
	logic       fv;
	logic [7:0] fb;
	logic       fc;
	logic       frdy;
	logic       frv;
	logic [7:0] frd;
	logic       fdone;
	logic [7:0] q;
	logic [7:0] r;
	logic [8:0] exq[$];
	logic [7:0] codes[4] = '{8'h06, 8'h07, 8'h08, 8'h03};
	int         n_mismatch = 0;
	int         n_checks = 0;
	int unsigned n;

	always #20 clk = ~clk;

	tdr_link_regs #(.PART_ID(PID), .REVISION(REV), .FIFO_DEPTH(4)) u_dut (
		.clk_i(clk), .rst_i(rst), .link_clock_line_i(lck), .link_data_line_i(line),
		.link_data_line_o(dq), .link_data_line_oe_o(doe), .halt_req_i(halt),
		.core_stall_o(stall), .prog_enable_o(prog), .fl_valid_o(fv), .fl_byte_o(fb),
		.fl_is_cmd_o(fc), .fl_ready_i(frdy), .fl_rvalid_i(frv), .fl_rdata_i(frd),
		.fl_done_i(fdone));

	tdr_link_host u_host (.clk_i(clk), .dev_d_i(dq), .dev_oe_i(doe), .ck_o(lck),
		.line_o(line));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] t;
		u_host.frame(1'b1, 1'b1, a, t);
		u_host.frame(1'b1, 1'b0, d, t);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		u_host.frame(1'b1, 1'b1, a, d);
		u_host.frame(1'b0, 1'b0, 8'h00, d);
	endtask : rd

	task automatic st(output logic [7:0] d);
		u_host.frame(1'b0, 1'b1, 8'h00, d);
	endtask : st

	// Flash side stalls at random while the model queue empties
	task automatic drain;
		for (int k = 0; k < 200 && exq.size() > 0; k++) begin
			@(posedge clk);
			frdy <= 1'($urandom);
			@(negedge clk);
			if (fv === 1'b1 && frdy === 1'b1) begin
				chk({7'h00, fc}, {7'h00, exq[0][8]});
				chk(fb, exq[0][7:0]);
				void'(exq.pop_front());
			end
		end
		chk(8'(exq.size()), 8'h00);
	endtask : drain

	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		halt = 1'b0;
		frdy = 1'b0;
		frv = 1'b0;
		frd = 8'h00;
		fdone = 1'b0;
		n = $urandom(21);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk({6'h00, stall, prog}, 8'h00);
		rd(8'h00, q);
		chk(q, PID);
		rd(8'h01, q);
		chk(q, REV);
		wr(8'h00, 8'(~PID));
		wr(8'h01, 8'($urandom));
		rd(8'h00, q);
		chk(q, PID);
		rd(8'h01, q);
		chk(q, REV);
		rd(8'h77, q);
		chk(q, 8'h00);
		@(posedge clk);
		halt <= 1'b1;
		repeat (3) @(posedge clk);
		chk({7'h00, stall}, 8'h01);
		halt <= 1'b0;
		// Data writes refused while locked
		wr(8'hb4, 8'h06);
		repeat (4) @(posedge clk);
		chk({7'h00, fv}, 8'h00);
		chk({7'h00, stall}, 8'h00);
		wr(8'h02, 8'h01);
		wr(8'h02, 8'h02);
		wr(8'h02, 8'h05);
		wr(8'h02, 8'h01);
		chk({7'h00, prog}, 8'h00);
		wr(8'h02, 8'h02);
		wr(8'h02, 8'h01);
		repeat (3) @(posedge clk);
		chk({6'h00, stall, prog}, 8'h03);
		st(q);
		chk(q, 8'h01);
		rd(8'h02, q);
		chk(q, 8'h01);
		wr(8'hb4, 8'h55);
		st(q);
		chk(q, 8'h09);
		st(q);
		chk(q, 8'h01);
		// Each command fills the FIFO with the flash side stalled
		foreach (codes[c]) begin
			@(posedge clk);
			frdy <= 1'b0;
			wr(8'hb4, codes[c]);
			exq.push_back({1'b1, codes[c]});
			for (int j = 0; j < 3; j++) begin
				r = 8'($urandom);
				wr(8'hb4, r);
				exq.push_back({1'b0, r});
			end
			st(q);
			chk(q, 8'h05);
			drain();
			@(posedge clk);
			fdone <= 1'b1;
			@(posedge clk);
			fdone <= 1'b0;
		end
		// Read-back byte toward the host
		r = 8'($urandom);
		frv <= 1'b1;
		frd <= r;
		@(posedge clk);
		frv <= 1'b0;
		st(q);
		chk(q, 8'h03);
		rd(8'hb4, q);
		chk(q, r);
		st(q);
		chk(q, 8'h01);
		wr(8'h02, 8'h00);
		chk({7'h00, prog}, 8'h01);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk({6'h00, stall, prog}, 8'h00);
		rd(8'h00, q);
		chk(q, PID);
		wrap_up();
	end
endmodule : two_wire_debug_flash_regs_test
